// file: vilc_pkg.sv
// constants and types for the video input lock control block
// Overview of operation
// - swap bit low routes port a to lane a, high swaps ports.
// - truncate bit high zeroes the two low bits of both ports.
// - timing words or external syncs reset horizontal and vertical counters.
// - blanking in line-locked or D1 puts luma/chroma blank on timing words.
// - blanking with subcarrier-sampled D2 puts sync tip on timing words.
// - invert bit high flips the chroma sample msb.
// - primary swap low feeds lane a primary, lane b secondary.
// - clock select high is line-locked, low is subcarrier-locked clocking.
// - companion protocol bit acts only in lock mode 10.
// - lock field: 00 line, 01 subcarrier, 10 input processor, 11 D1.
// - burst loop bit 0 gives frequency lock, 1 phase lock.
// - colour kill disable high stops colour killing.
// - demodulator bypass high routes chroma around the demodulator.
// - upsample bit high interpolates 0:2:2 colour difference data.
package vilc_pkg;
  localparam int VID_W = 10;
  localparam int REG_W = 8;
  // printed offsets are register indices; byte address is four times
  localparam logic [7:0] IDX_INPUT_PATH = 8'h01;
  localparam logic [7:0] IDX_BURST_LOCK = 8'h02;
  localparam logic [31:0] ADDR_INPUT_PATH = {22'h0, IDX_INPUT_PATH, 2'b00};
  localparam logic [31:0] ADDR_BURST_LOCK = {22'h0, IDX_BURST_LOCK, 2'b00};
  localparam logic [REG_W-1:0] RST_INPUT_PATH = 8'h00;
  localparam logic [REG_W-1:0] RST_BURST_LOCK = 8'h00;
  localparam logic [REG_W-1:0] WRITE_MASK = 8'h7f;
  // input path field positions
  localparam int B_SWAP = 6;
  localparam int B_TRUNC = 5;
  localparam int B_TRS_EN = 4;
  localparam int B_BLANK = 3;
  localparam int B_MSB_INV = 2;
  localparam int B_AB_SWAP = 1;
  localparam int B_CLK_SEL = 0;
  // burst lock field positions
  localparam int B_COMPANION = 6;
  localparam int B_LOCK_LO = 4;
  localparam int B_BLM = 3;
  localparam int B_COLOR_KILL_DISABLE = 2;
  localparam int B_DEMOD = 1;
  localparam int B_UPS = 0;
  // timing word codes and replacement levels
  localparam logic [VID_W-1:0] WORD_ONES = 10'h3ff;
  localparam logic [VID_W-1:0] WORD_ZERO = 10'h000;
  localparam logic [VID_W-1:0] LUMA_BLANK = 10'h040;
  localparam logic [VID_W-1:0] CHROMA_BLANK = 10'h200;
  localparam logic [VID_W-1:0] SYNC_TIP = 10'h010;
  localparam int XYZ_V = 7;
  localparam int XYZ_H = 6;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {
    LOCK_LINE = 2'b00,
    LOCK_SUBCARRIER = 2'b01,
    LOCK_VIP = 2'b10,
    LOCK_D1 = 2'b11
  } vilc_lock_e;

  typedef enum logic [3:0] {
    TRS_IDLE = 4'b0001,
    TRS_ONES = 4'b0010,
    TRS_ZERO1 = 4'b0100,
    TRS_ZERO2 = 4'b1000
  } vilc_trs_e;

  typedef struct packed {
    logic [VID_W-1:0] primary;
    logic [VID_W-1:0] secondary;
  } vilc_pair_s;

  typedef struct packed {
    vilc_lock_e lock_mode;
    logic       companion_protocol;
    logic       line_locked_clock;
    logic       burst_phase_lock;
    logic       color_kill_en;
    logic       demod_bypass;
    logic       chroma_upsample_en;
    logic       trs_timing_en;
  } vilc_mode_s;
endpackage

// file: vilc_props.sv
// assertions on the ports of the video input lock control block
`timescale 1ns/10ps
module vilc_props
  import vilc_pkg::*;
(
  // clock, reset, bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // stream and decoder side
  input wire logic        video_ready,
  input wire vilc_pair_s  pair_data,
  input wire logic        pair_valid,
  input wire logic        pair_ready,
  input wire logic        h_reset,
  input wire logic        v_reset,
  input wire vilc_mode_s  mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc   = hsel & hready & ce & hwrite & (htrans == HTRANS_NONSEQ);
  wire wr_ip = acc & (haddr == ADDR_INPUT_PATH);
  wire wr_bl = acc & (haddr == ADDR_BURST_LOCK);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_top: assert property (hrdata[31:7] == '0)
    else $error("read data top bits set");
  a_lock_mode: assert property ($past(wr_bl, 2) |->
    mode.lock_mode == $past(hwdata[5:4])) else $error("lock mode wrong");
  a_burst_bits: assert property ($past(wr_bl, 2) |->
    {mode.burst_phase_lock, mode.color_kill_en, mode.demod_bypass,
     mode.chroma_upsample_en} == ($past(hwdata[3:0]) ^ 4'b0100))
    else $error("burst mode bits wrong");
  a_clock_sel: assert property ($past(wr_ip, 2) |->
    mode.line_locked_clock == $past(hwdata[0]) &&
    mode.trs_timing_en == $past(hwdata[4])) else $error("input mode wrong");
  a_companion_gate: assert property (mode.companion_protocol |->
    mode.lock_mode == LOCK_VIP) else $error("companion outside mode 10");
  a_hreset_pulse: assert property (h_reset |=> !h_reset)
    else $error("h_reset longer than one cycle");
  a_vreset_pulse: assert property ($rose(v_reset) |=> $fell(v_reset))
    else $error("v_reset longer than one cycle");
  a_head_hold: assert property (pair_valid && !pair_ready && ce |=>
    pair_valid && $stable(pair_data)) else $error("head changed in stall");
  a_full_valid: assert property (!video_ready && pair_ready && ce |=>
    video_ready) else $error("full fifo not freed by a pop");
endmodule

bind vilc_top vilc_props i_vilc_props (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .video_ready, .pair_data, .pair_valid, .pair_ready, .h_reset, .v_reset,
  .mode);

// file: vilc_src.sv
// partner model: video source on the two pixel ports and sync pins
`timescale 1ns/10ps
module vilc_src
  import vilc_pkg::*;
(
  // clock and back pressure
  input  wire logic             hclk,
  input  wire logic             video_ready,
  // pixel and sync pins
  output logic      [VID_W-1:0] video_port_a,
  output logic      [VID_W-1:0] video_port_b,
  output logic                  video_valid,
  output logic                  line_sync,
  output logic                  frame_sync
);
  logic rdy_q;
  initial begin
    video_port_a = '0;
    video_port_b = '0;
    video_valid  = 1'b0;
    line_sync    = 1'b0;
    frame_sync   = 1'b0;
  end
  always @(negedge hclk) rdy_q = video_ready;
  // luma on port a, chroma on port b; stops while back pressure is seen
  task automatic send(input logic [VID_W-1:0] a, b);
    while (!rdy_q) begin
      video_valid  <= 1'b0;
      video_port_a <= ~video_port_a;
      @(posedge hclk);
    end
    video_port_a <= a;
    video_port_b <= b;
    video_valid  <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic idle();
    video_valid  <= 1'b0;
    video_port_a <= ~video_port_a;
    video_port_b <= ~video_port_b;
    @(posedge hclk);
  endtask
  task automatic sync_pulse(input logic l, f);
    line_sync  <= l;
    frame_sync <= f;
    repeat (3) @(posedge hclk);
    line_sync  <= 1'b0;
    frame_sync <= 1'b0;
    @(posedge hclk);
  endtask
endmodule

// file: vilc_top.sv
// fifo and top level of the video input lock control block
`timescale 1ns/10ps
module vilc_fifo
  import vilc_pkg::*;
#(
  parameter int WIDTH = 20,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              empty = wr_ptr == rd_ptr;
  wire              full = (wr_ptr[AW] != rd_ptr[AW]) &&
                           (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              push = ce && in_valid && !full;
  wire              pop = ce && out_valid && out_ready;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

module vilc_top
  import vilc_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock, reset, enable
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // video pins
  input  wire logic [VID_W-1:0] video_port_a,
  input  wire logic [VID_W-1:0] video_port_b,
  input  wire logic             video_valid,
  output logic                  video_ready,
  input  wire logic             line_sync,
  input  wire logic             frame_sync,
  // decoder side
  output vilc_pair_s            pair_data,
  output logic                  pair_valid,
  input  wire logic             pair_ready,
  output logic                  h_reset,
  output logic                  v_reset,
  output vilc_mode_s            mode
);
  logic [REG_W-1:0] input_path_control;
  logic [REG_W-1:0] burst_lock_control;

  // ---------------- ahb-lite register slave
  logic        wr_pend;
  logic [31:0] addr_q;
  wire         take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire         rd_take = take && !hwrite;
  wire         hit_input = haddr == ADDR_INPUT_PATH;
  wire         hit_burst = haddr == ADDR_BURST_LOCK;
  wire [REG_W-1:0] wr_val = hwdata[REG_W-1:0] & WRITE_MASK;
  wire         wr_input = wr_pend && addr_q == ADDR_INPUT_PATH;
  wire         wr_burst = wr_pend && addr_q == ADDR_BURST_LOCK;
  // a read right behind a write to the same register sees the new value
  wire [REG_W-1:0] ip_now = wr_input ? wr_val : input_path_control;
  wire [REG_W-1:0] bl_now = wr_burst ? wr_val : burst_lock_control;
  wire [REG_W-1:0] rd_sel = hit_input ? ip_now :
                            hit_burst ? bl_now : '0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q <= '0;
      hrdata <= '0;
    end else if (ce) begin
      wr_pend <= take && hwrite;
      if (take) addr_q <= haddr;
      if (rd_take) hrdata <= {24'h0, rd_sel};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_path_control <= RST_INPUT_PATH;
      burst_lock_control <= RST_BURST_LOCK;
    end else if (ce) begin
      if (wr_input) input_path_control <= wr_val;
      if (wr_burst) burst_lock_control <= wr_val;
    end
  end

  // ---------------- control fields
  wire        swap_sel = input_path_control[B_SWAP];
  wire        trunc = input_path_control[B_TRUNC];
  wire        trs_en = input_path_control[B_TRS_EN];
  wire        blank_en = input_path_control[B_BLANK];
  wire        msb_inv = input_path_control[B_MSB_INV];
  wire        ab_swap = input_path_control[B_AB_SWAP];
  wire [1:0]  lock_raw = burst_lock_control[B_LOCK_LO+1:B_LOCK_LO];
  vilc_lock_e lock_mode;
  assign lock_mode = vilc_lock_e'(lock_raw);

  // mode outputs straight from the register flops
  assign mode.lock_mode = lock_mode;
  assign mode.companion_protocol = (lock_mode == LOCK_VIP) &&
    burst_lock_control[B_COMPANION];
  assign mode.line_locked_clock = input_path_control[B_CLK_SEL];
  assign mode.burst_phase_lock = burst_lock_control[B_BLM];
  assign mode.color_kill_en = !burst_lock_control[B_COLOR_KILL_DISABLE];
  assign mode.demod_bypass = burst_lock_control[B_DEMOD];
  assign mode.chroma_upsample_en = burst_lock_control[B_UPS];
  assign mode.trs_timing_en = trs_en;

  // ---------------- pin synchronisers
  logic [VID_W-1:0] pa_s1, pa_s2, pb_s1, pb_s2;
  logic [2:0]       ctl_s1, ctl_s2;
  logic             ls_d, fs_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_s1 <= '0;
      pa_s2 <= '0;
      pb_s1 <= '0;
      pb_s2 <= '0;
      ctl_s1 <= '0;
      ctl_s2 <= '0;
      ls_d <= 1'b0;
      fs_d <= 1'b0;
    end else if (ce) begin
      pa_s1 <= video_port_a;
      pa_s2 <= pa_s1;
      pb_s1 <= video_port_b;
      pb_s2 <= pb_s1;
      ctl_s1 <= {video_valid, line_sync, frame_sync};
      ctl_s2 <= ctl_s1;
      ls_d <= ctl_s2[1];
      fs_d <= ctl_s2[0];
    end
  end

  wire in_valid = ctl_s2[2];
  wire ls_rise = ctl_s2[1] && !ls_d;
  wire fs_rise = ctl_s2[0] && !fs_d;

  // ---------------- input processing
  wire [VID_W-1:0] trunc_mask = trunc ? {{(VID_W-2){1'b1}}, 2'b00}
                                      : {VID_W{1'b1}};
  wire [VID_W-1:0] port_a_t = pa_s2 & trunc_mask;
  wire [VID_W-1:0] port_b_t = pb_s2 & trunc_mask;
  // luma is expected on lane a and chroma on lane b
  wire [VID_W-1:0] lane_a = swap_sel ? port_b_t : port_a_t;
  wire [VID_W-1:0] lane_b = swap_sel ? port_a_t : port_b_t;
  wire [VID_W-1:0] lane_b_inv = lane_b ^ {msb_inv, {(VID_W-1){1'b0}}};

  // timing reference detector on lane a
  vilc_trs_e trs_state;
  vilc_trs_e next_trs_state;
  logic      word_phase;
  logic      v_prev;
  wire       is_ones = lane_a == WORD_ONES;
  wire       is_zero = lane_a == WORD_ZERO;
  wire       is_xyz = trs_state == TRS_ZERO2;

  always_comb begin
    case (trs_state)
      TRS_IDLE:  next_trs_state = is_ones ? TRS_ONES : TRS_IDLE;
      TRS_ONES:  next_trs_state = is_zero ? TRS_ZERO1 :
                                  is_ones ? TRS_ONES : TRS_IDLE;
      TRS_ZERO1: next_trs_state = is_zero ? TRS_ZERO2 :
                                  is_ones ? TRS_ONES : TRS_IDLE;
      TRS_ZERO2: next_trs_state = is_ones ? TRS_ONES : TRS_IDLE;
      default:   next_trs_state = TRS_IDLE;
    endcase
  end

  // words of a preamble or its code word are replaced when blanking
  wire timing_word = is_ones || is_zero || is_xyz;
  wire d2_input = lock_mode == LOCK_SUBCARRIER;
  wire [VID_W-1:0] ll_blank_a = word_phase ? LUMA_BLANK : CHROMA_BLANK;
  wire [VID_W-1:0] blank_a = d2_input ? SYNC_TIP
                                      : ll_blank_a;
  wire [VID_W-1:0] blank_b = d2_input ? SYNC_TIP : CHROMA_BLANK;
  wire do_blank = blank_en && timing_word;
  wire [VID_W-1:0] proc_a = do_blank ? blank_a : lane_a;
  wire [VID_W-1:0] proc_b = do_blank ? blank_b : lane_b_inv;

  vilc_pair_s next_pair;
  assign next_pair.primary = ab_swap ? proc_b : proc_a;
  assign next_pair.secondary = ab_swap ? proc_a : proc_b;

  // counter resets come from code words or from the sync pins
  wire trs_h = is_xyz && lane_a[XYZ_H];
  wire trs_v = is_xyz && lane_a[XYZ_V] && !v_prev;

  // ---------------- output stage and buffering
  vilc_pair_s stage_data;
  logic       stage_valid;
  wire        fifo_ready;
  wire        advance = !stage_valid || fifo_ready;
  wire        load = in_valid && advance;

  assign video_ready = fifo_ready;

  // with timing words enabled only a code word actually taken in may pulse, so a stall cannot repeat it
  wire next_h_reset = trs_en ? (load && trs_h) : ls_rise;
  wire next_v_reset = trs_en ? (load && trs_v) : fs_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trs_state <= TRS_IDLE;
      word_phase <= 1'b0;
      v_prev <= 1'b0;
      stage_valid <= 1'b0;
      stage_data <= '0;
      h_reset <= 1'b0;
      v_reset <= 1'b0;
    end else if (ce) begin
      h_reset <= next_h_reset;
      v_reset <= next_v_reset;
      if (load) begin
        trs_state <= next_trs_state;
        word_phase <= is_xyz ? 1'b0 : !word_phase;
        if (is_xyz) v_prev <= lane_a[XYZ_V];
        stage_data <= next_pair;
      end
      if (advance) stage_valid <= in_valid;
    end
  end

  vilc_fifo #(
    .WIDTH ($bits(vilc_pair_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .in_valid  (stage_valid),
    .in_ready  (fifo_ready),
    .in_data   (stage_data),
    .out_valid (pair_valid),
    .out_ready (pair_ready),
    .out_data  (pair_data)
  );
endmodule

// file: vilc_top_tb.sv
// self-checking testbench for the video input lock control block
`timescale 1ns/10ps
module vilc_top_tb;
  import vilc_pkg::*;
  logic             hclk, hresetn, ce, hsel, hwrite, pair_ready;
  logic             hreadyout, hresp, video_valid, video_ready;
  logic             line_sync, frame_sync, pair_valid, h_reset, v_reset;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, r;
  logic [VID_W-1:0] video_port_a, video_port_b;
  vilc_pair_s       pair_data;
  vilc_mode_s       mode;
  vilc_pair_s       exq[$];
  logic [7:0]       cfg;
  logic [1:0]       m;
  int               error_cnt, checks, hcnt, vcnt, n;
  logic [7:0]       cfgs[6] = '{8'h00, 8'h40, 8'h21, 8'h04, 8'h02, 8'h67};
  logic [9:0]       timing_reference_word[4] = '{10'h3ff, 10'h000, 10'h000, 10'h2c0};
  wire              hready = hreadyout;
  vilc_top i_vilc_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .video_port_a,
    .video_port_b, .video_valid, .video_ready, .line_sync, .frame_sync,
    .pair_data, .pair_valid, .pair_ready, .h_reset, .v_reset, .mode);
  vilc_src i_vilc_src (.hclk, .video_ready, .video_port_a, .video_port_b,
    .video_valid, .line_sync, .frame_sync);
  always #20 hclk = ~hclk;
  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (!hready);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000);
    chk("hrdata", e, r);
  endtask
  function automatic vilc_pair_s exp_pair(input logic [9:0] a, b);
    logic [9:0] la, lb;
    la = cfg[B_SWAP] ? b : a;
    lb = cfg[B_SWAP] ? a : b;
    if (cfg[B_TRUNC]) begin
      la[1:0] = 2'b00;
      lb[1:0] = 2'b00;
    end
    lb[9] = lb[9] ^ cfg[B_MSB_INV];
    return cfg[B_AB_SWAP] ? {lb, la} : {la, lb};
  endfunction
  task automatic px(input logic [9:0] a, b);
    exq.push_back(exp_pair(a, b));
    i_vilc_src.send(a, b);
  endtask
  task automatic drain();
    n = 0;
    while (exq.size() != 0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    @(negedge hclk);
    chk("pending", 0, exq.size());
    chk("pair_valid", 0, pair_valid);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (h_reset) hcnt++;
    if (v_reset) vcnt++;
    if (hresetn && pair_valid && pair_ready) begin
      if (exq.size() == 0) chk("extra pair", 1, 0);
      else chk("pair_data", exq.pop_front(), pair_data);
    end
  end
  initial begin
    #2_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {ce, pair_ready, hsize} = 5'b11010;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    @(posedge hclk);
    rd_chk(ADDR_INPUT_PATH, {24'h0, RST_INPUT_PATH});
    rd_chk(ADDR_BURST_LOCK, {24'h0, RST_BURST_LOCK});
    chk("kill_en", 1, mode.color_kill_en);
    bus(1'b1, ADDR_INPUT_PATH, 32'h0000_007f);
    rd_chk(ADDR_INPUT_PATH, 32'h0000_007f);
    bus(1'b1, 32'h0000_000c, 32'h0000_00ff);
    rd_chk(32'h0000_000c, 32'h0000_0000);
    ce <= 1'b0;
    bus(1'b1, ADDR_INPUT_PATH, 32'h0000_0000);
    ce <= 1'b1;
    rd_chk(ADDR_INPUT_PATH, 32'h0000_007f);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      bus(1'b1, ADDR_BURST_LOCK, {26'h1, m, m, m});
      @(posedge hclk);
      chk("lock", m, mode.lock_mode);
      chk("companion", m == 2'b10, mode.companion_protocol);
      chk("phase_lock", m[1], mode.burst_phase_lock);
      chk("kill_en", !m[0], mode.color_kill_en);
      chk("bypass", m[1], mode.demod_bypass);
      chk("upsample", m[0], mode.chroma_upsample_en);
      rd_chk(ADDR_BURST_LOCK, {26'h1, m, m, m});
    end
    for (int k = 0; k < 6; k++) begin
      cfg = cfgs[k];
      bus(1'b1, ADDR_INPUT_PATH, {24'h0, cfg});
      @(posedge hclk);
      chk("line_clk", cfg[B_CLK_SEL], mode.line_locked_clock);
      for (int j = 0; j < 4; j++) px(10'h1a5 + 10'(j * 37), 10'h2f6 - 10'(j));
      i_vilc_src.idle();
      drain();
    end
    pair_ready <= 1'b0;
    fork
      begin
        for (int j = 0; j < FIFO_DEPTH_DEF + 1; j++)
          px(10'h100 + 10'(j), 10'h155);
        i_vilc_src.idle();
      end
    join_none
    n = 0;
    while (video_ready && n < 200) begin
      @(negedge hclk);
      n++;
    end
    chk("video_ready", 0, video_ready);
    repeat (20) @(posedge hclk);
    pair_ready <= 1'b1;
    drain();
    cfg = 8'h18;
    bus(1'b1, ADDR_INPUT_PATH, {24'h0, cfg});
    bus(1'b1, ADDR_BURST_LOCK, 32'h0000_0010);
    {hcnt, vcnt} = '0;
    foreach (timing_reference_word[j]) begin
      exq.push_back({SYNC_TIP, SYNC_TIP});
      i_vilc_src.send(timing_reference_word[j], 10'h155);
    end
    px(10'h123, 10'h155);
    i_vilc_src.idle();
    drain();
    chk("h_trs", 1, hcnt);
    chk("v_trs", 1, vcnt);
    i_vilc_src.sync_pulse(1'b1, 1'b1);
    repeat (8) @(posedge hclk);
    chk("h_ignored", 1, hcnt);
    bus(1'b1, ADDR_INPUT_PATH, 32'h0000_0000);
    i_vilc_src.sync_pulse(1'b1, 1'b1);
    repeat (8) @(posedge hclk);
    chk("h_sync", 2, hcnt);
    chk("v_sync", 2, vcnt);
    print_verdict();
  end
endmodule
